//--- shared/sfcap_pkg.sv
// package: opcodes, address layout, timing constants for serial flash command framing
package sfcap_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 100;
  localparam int SUPPLY_TO_SELECT_DELAY_MS = 1;
  localparam int POWERUP_WRITE_DELAY_MS = 20;
  localparam int SELECT_DELAY_CYC = SUPPLY_TO_SELECT_DELAY_MS * CLK_MHZ * 1000;
  localparam int WRITE_DELAY_CYC = POWERUP_WRITE_DELAY_MS * CLK_MHZ * 1000;
  // ==========================================================
  // address layout, 264-byte pages
  localparam int PAGE_SIZE = 264;
  localparam int RSV_BITS = 6;
  localparam int PAGE_BITS = 9;
  localparam int BYTE_BITS = 9;
  localparam int ADDR_BYTES = 3;
  localparam int BLOCK_BITS = 5;
  localparam int HDR_BITS = 32;
  localparam int SHIFT_W = 64;
  localparam int PAGE_FIELD_MSB = 17;
  localparam int BYTE_FIELD_MSB = 8;
  localparam int BYTE_FIELD_LSB = 0;
  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_READ_PAGE = 8'h03;
  localparam logic [7:0] OP_READ_FAST = 8'h0B;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OP_PAGE_TO_BUF = 8'h53;
  localparam logic [7:0] OP_AUTO_REWRITE = 8'h58;
  localparam logic [7:0] OP_PAGE_COMPARE = 8'h60;
  localparam logic [7:0] OP_READ_SECURITY = 8'h77;
  localparam logic [7:0] OP_ERASE_PROT = 8'h7C;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_PROG_VIA_BUF = 8'h82;
  localparam logic [7:0] OP_BUF_TO_PAGE_E = 8'h83;
  localparam logic [7:0] OP_BUF_WRITE = 8'h84;
  localparam logic [7:0] OP_BUF_TO_PAGE = 8'h88;
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_DEEP_DOWN = 8'hB9;
  localparam logic [7:0] OP_RESUME = 8'hAB;
  localparam logic [7:0] OP_BUF_READ_LO = 8'hD1;
  localparam logic [7:0] OP_PAGE_READ = 8'hD2;
  localparam logic [7:0] OP_BUF_READ = 8'hD4;
  localparam logic [7:0] OP_STATUS = 8'hD7;
  localparam logic [7:0] OP_CONT_READ = 8'hE8;
  // ==========================================================
  // identification (values arbitrary)
  localparam logic [7:0] ID_BYTE0 = 8'h5A;
  localparam logic [7:0] ID_BYTE1 = 8'h3C;
  localparam logic [7:0] ID_BYTE2 = 8'h01;
  localparam logic [7:0] ID_BYTE3 = 8'h00;
  localparam logic [7:0] STATUS_READY = 8'h80;
  localparam logic [7:0] STATUS_BUSY = 8'h00;

  typedef enum logic [2:0] {
    PWR_RESET = 3'h0,
    PWR_STANDBY = 3'h1,
    PWR_ACTIVE = 3'h2,
    PWR_DEEP = 3'h3
  } sfcap_pwr_e;

  // address bytes for an opcode
  function automatic logic [1:0] addr_bytes(input logic [7:0] op);
    case (op)
      OP_READ_ID, OP_DEEP_DOWN, OP_RESUME, OP_STATUS: addr_bytes = 2'h0;
      default: addr_bytes = 2'h3;
    endcase
  endfunction : addr_bytes

  // extra dummy bytes after the address
  function automatic logic [2:0] dummy_bytes(input logic [7:0] op);
    case (op)
      OP_READ_FAST, OP_BUF_READ: dummy_bytes = 3'h1;
      OP_PAGE_READ, OP_CONT_READ: dummy_bytes = 3'h4;
      default: dummy_bytes = 3'h0;
    endcase
  endfunction : dummy_bytes

  // true when the opcode returns data on serial output
  function automatic logic is_read(input logic [7:0] op);
    case (op)
      OP_READ_PAGE, OP_READ_FAST, OP_READ_SECURITY, OP_READ_ID, OP_BUF_READ_LO,
      OP_PAGE_READ, OP_BUF_READ, OP_STATUS, OP_CONT_READ: is_read = 1'b1;
      default: is_read = 1'b0;
    endcase
  endfunction : is_read

  // true for program and erase commands
  function automatic logic is_write(input logic [7:0] op);
    case (op)
      OP_BLOCK_ERASE, OP_AUTO_REWRITE, OP_ERASE_PROT, OP_PAGE_ERASE, OP_PROG_VIA_BUF,
      OP_BUF_TO_PAGE_E, OP_BUF_TO_PAGE: is_write = 1'b1;
      default: is_write = 1'b0;
    endcase
  endfunction : is_write
endpackage : sfcap_pkg

//--- shared/sfcap_link_if.sv
// interface: serial flash link between host controller and device
`timescale 1ns/100ps
interface sfcap_link_if;
  logic csN;
  logic sck;
  logic si;
  logic so;
  logic soOe;
  logic soWire;

  // undriven output reads high, as with a pull-up
  assign soWire = soOe ? so : 1'b1;

  modport device (
    input csN,
    input sck,
    input si,
    output so,
    output soOe
  );
  modport host (
    output csN,
    output sck,
    output si,
    input soWire
  );
endinterface : sfcap_link_if

//--- logic/sfcap_device.sv
// device end: frames opcode and address, detects bus mode, power-on gating
//
// What this block does
// - opcode, three address bytes, 6/9/9 layout
// - page field decoded for page commands
// - byte field decoded for byte commands
// - filler, dummy and no-address byte counts
// - start in mode 3 after reset
// - serial output released after reset
// - instruction only after select falling edge
// - mode chosen at each select falling edge
// - held in reset below threshold
// - no response during power-on reset
// - host waits before first read select
// - host waits before program or erase
// - enter standby after power-up
// - 53h transfers page into buffer
// - 9Fh returns identification bytes
// - ABh resumes from deep power-down
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
module sfcap_device #(
  parameter int WRITE_DELAY = sfcap_pkg::WRITE_DELAY_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic powerGood,
  sfcap_link_if.device link,
  output logic mode3,
  output logic standby,
  output logic deepDown,
  output logic cmdValid,
  output logic [7:0] cmdOpcode,
  output logic [8:0] cmdPage,
  output logic [8:0] cmdByte,
  output logic [4:0] cmdBlock,
  output logic pageToBuf,
  output logic writeReady
);
  initial begin
    if (WRITE_DELAY < 1) $error("WRITE_DELAY must be at least 1");
  end

  // ==========================================================
  // state
  typedef struct packed {
    sfcap_pkg::sfcap_pwr_e pwr;
    logic mode3;
    logic csPrev;
    logic sckPrev;
    logic armed;
    logic [6:0] bitCnt;
    logic [31:0] hdr;
    logic hdrDone;
    logic [7:0] op;
    logic [31:0] outShift;
    logic so;
    logic soOe;
    logic cmdValid;
    logic [8:0] page;
    logic [8:0] byteAddr;
    logic [4:0] block;
    logic pageToBuf;
    logic [31:0] wrCnt;
  } sfcap_dev_s;

  sfcap_dev_s st;
  sfcap_dev_s next_st;
  logic csFall;
  logic csRise;
  logic sampleEdge;
  logic shiftEdge;
  logic [31:0] nextHdr;
  logic [6:0] hdrLen;

  assign csFall = st.csPrev && !link.csN;
  assign csRise = !st.csPrev && link.csN;
  // mode 0 and 3 both sample on rising, shift on falling
  assign sampleEdge = !link.csN && !st.sckPrev && link.sck;
  assign shiftEdge = !link.csN && st.sckPrev && !link.sck;

  always_comb begin
    next_st = st;
    nextHdr = {st.hdr[30:0], link.si};
    hdrLen = 7'(8 + 8 * sfcap_pkg::addr_bytes(st.op));
    next_st.csPrev = link.csN;
    next_st.sckPrev = link.sck;
    next_st.cmdValid = 1'b0;
    next_st.pageToBuf = 1'b0;
    if (!powerGood) begin
      next_st = '0;
      next_st.mode3 = 1'b1;
      next_st.csPrev = link.csN;
      next_st.sckPrev = link.sck;
    end else begin
      if (st.pwr == sfcap_pkg::PWR_RESET) begin
        next_st.pwr = sfcap_pkg::PWR_STANDBY;
      end
      if (st.wrCnt < 32'(WRITE_DELAY)) begin
        next_st.wrCnt = st.wrCnt + 32'h1;
      end
      if (csFall && st.pwr != sfcap_pkg::PWR_RESET) begin
        next_st.mode3 = link.sck;
        next_st.armed = 1'b1;
        next_st.bitCnt = '0;
        next_st.hdrDone = 1'b0;
        next_st.op = '0;
        if (st.pwr == sfcap_pkg::PWR_STANDBY) begin
          next_st.pwr = sfcap_pkg::PWR_ACTIVE;
        end
      end
      if (csRise) begin
        // partial header raises no cmdValid and no address fields; an opcode byte already taken stays on cmdOpcode
        next_st.armed = 1'b0;
        next_st.hdrDone = 1'b0;
        next_st.bitCnt = '0;
        next_st.soOe = 1'b0;
        if (st.pwr == sfcap_pkg::PWR_ACTIVE) begin
          next_st.pwr = sfcap_pkg::PWR_STANDBY;
        end
      end
      if (sampleEdge && st.armed && !st.hdrDone) begin
        next_st.hdr = nextHdr;
        next_st.bitCnt = st.bitCnt + 7'h1;
        if (st.bitCnt == 7'd7) begin
          next_st.op = nextHdr[7:0];
        end
        if (st.bitCnt >= 7'd7 &&
            (st.bitCnt + 7'h1) == ((st.bitCnt == 7'd7) ?
              7'(8 + 8 * sfcap_pkg::addr_bytes(nextHdr[7:0])) : hdrLen)) begin
          next_st.hdrDone = 1'b1;
          next_st.cmdValid = 1'b1;
          if (st.bitCnt != 7'd7) begin
            // reserved bits 23:18 ignored
            next_st.page = nextHdr[sfcap_pkg::PAGE_FIELD_MSB -: sfcap_pkg::PAGE_BITS];
            next_st.block = nextHdr[sfcap_pkg::PAGE_FIELD_MSB -: sfcap_pkg::BLOCK_BITS];
            next_st.byteAddr = nextHdr[sfcap_pkg::BYTE_FIELD_MSB:sfcap_pkg::BYTE_FIELD_LSB];
          end else begin
            next_st.op = nextHdr[7:0];
          end
          if (st.bitCnt != 7'd7 && st.op == sfcap_pkg::OP_PAGE_TO_BUF &&
              st.pwr == sfcap_pkg::PWR_ACTIVE) begin
            next_st.pageToBuf = 1'b1;
          end
          if (st.bitCnt == 7'd7 && nextHdr[7:0] == sfcap_pkg::OP_RESUME) begin
            next_st.pwr = sfcap_pkg::PWR_ACTIVE;
          end
          if (st.bitCnt == 7'd7 && nextHdr[7:0] == sfcap_pkg::OP_DEEP_DOWN) begin
            next_st.pwr = sfcap_pkg::PWR_DEEP;
          end
          if (st.bitCnt == 7'd7 && nextHdr[7:0] == sfcap_pkg::OP_READ_ID) begin
            next_st.outShift = {sfcap_pkg::ID_BYTE0, sfcap_pkg::ID_BYTE1,
                                sfcap_pkg::ID_BYTE2, sfcap_pkg::ID_BYTE3};
          end else if (st.bitCnt == 7'd7 && nextHdr[7:0] == sfcap_pkg::OP_STATUS) begin
            next_st.outShift = {4{sfcap_pkg::STATUS_READY}};
          end else begin
            next_st.outShift = '0;
          end
        end
      end
      // deep power-down: only resume is honoured
      if (st.pwr == sfcap_pkg::PWR_DEEP && next_st.cmdValid &&
          next_st.op != sfcap_pkg::OP_RESUME) begin
        next_st.cmdValid = 1'b0;
        next_st.pageToBuf = 1'b0;
        next_st.pwr = sfcap_pkg::PWR_DEEP;
      end
      if (shiftEdge && st.hdrDone && sfcap_pkg::is_read(st.op) &&
          st.pwr != sfcap_pkg::PWR_DEEP) begin
        next_st.soOe = 1'b1;
        next_st.so = st.outShift[31];
        next_st.outShift = {st.outShift[30:0], st.outShift[31]};
      end
    end
    if (srst) begin
      next_st = '0;
      next_st.mode3 = 1'b1;
      next_st.soOe = 1'b0;
      next_st.csPrev = 1'b1;
      next_st.sckPrev = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  assign link.so = st.so;
  assign link.soOe = st.soOe;
  assign mode3 = st.mode3;
  assign standby = st.pwr == sfcap_pkg::PWR_STANDBY;
  assign deepDown = st.pwr == sfcap_pkg::PWR_DEEP;
  assign cmdValid = st.cmdValid;
  assign cmdOpcode = st.op;
  assign cmdPage = st.page;
  assign cmdByte = st.byteAddr;
  assign cmdBlock = st.block;
  assign pageToBuf = st.pageToBuf;
  assign writeReady = st.wrCnt >= 32'(WRITE_DELAY);
endmodule : sfcap_device

//--- logic/sfcap_host.sv
// host end: APB-controlled command framer driving the serial flash link
`timescale 1ns/100ps
module sfcap_host #(
  parameter int SELECT_DELAY = sfcap_pkg::SELECT_DELAY_CYC,
  parameter int WRITE_DELAY = sfcap_pkg::WRITE_DELAY_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sfcap_link_if.host link
);
  // register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;

  initial begin
    if (SELECT_DELAY < 1 || WRITE_DELAY < 1) $error("delays must be at least 1");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] op;
    logic [8:0] page;
    logic [8:0] byteAddr;
    logic [2:0] rdBytes;
    logic idleHigh;
    logic busy;
    logic [6:0] bitsLeft;
    logic [6:0] rdLeft;
    logic rdPend;
    logic [63:0] shOut;
    logic [31:0] rdata;
    logic csN;
    logic sck;
    logic si;
    logic [31:0] upCnt;
    logic [31:0] prdata;
  } sfcap_host_s;

  sfcap_host_s st;
  sfcap_host_s next_st;
  logic wrAcc;
  logic rdAcc;
  logic selOk;
  logic wrOk;
  logic [6:0] hdrBits;

  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && !penable && !pwrite;
  assign selOk = st.upCnt >= 32'(SELECT_DELAY);
  assign wrOk = st.upCnt >= 32'(WRITE_DELAY);

  always_comb begin
    next_st = st;
    hdrBits = 7'(8 + 8 * sfcap_pkg::addr_bytes(st.op) + 8 * sfcap_pkg::dummy_bytes(st.op));
    if (st.upCnt < 32'(WRITE_DELAY)) begin
      next_st.upCnt = st.upCnt + 32'h1;
    end
    if (rdAcc) begin
      case (paddr)
        REG_CMD: next_st.prdata = {24'h0, st.op};
        REG_ADDR: next_st.prdata = {14'h0, st.page, st.byteAddr};
        REG_CTRL: next_st.prdata = {28'h0, st.idleHigh, st.rdBytes};
        REG_STATUS: next_st.prdata = {29'h0, wrOk, selOk, st.busy};
        REG_RDATA: next_st.prdata = st.rdata;
        default: next_st.prdata = '0;
      endcase
    end
    if (wrAcc && !st.busy) begin
      case (paddr)
        REG_ADDR: begin
          next_st.page = pwdata[17:9];
          next_st.byteAddr = pwdata[8:0];
        end
        REG_CTRL: begin
          next_st.rdBytes = pwdata[2:0];
          next_st.idleHigh = pwdata[3];
          next_st.sck = pwdata[3];
        end
        REG_CMD: begin
          // refuse until the select wait has passed, and program or erase until the write wait has passed too
          if (selOk && (wrOk || !sfcap_pkg::is_write(pwdata[7:0]))) begin
            next_st.op = pwdata[7:0];
            next_st.busy = 1'b1;
            next_st.csN = 1'b0;
            next_st.sck = st.idleHigh;
            next_st.bitsLeft = 7'(8 + 8 * sfcap_pkg::addr_bytes(pwdata[7:0]) +
                                  8 * sfcap_pkg::dummy_bytes(pwdata[7:0]));
            next_st.rdLeft = 7'(8 * st.rdBytes);
            next_st.shOut = {pwdata[7:0], 6'h0, st.page, st.byteAddr, 32'h0};
            if (!st.idleHigh) begin
              // mode 0: first bit must stand on si before the first rising clock
              next_st.si = pwdata[7];
              next_st.shOut = {pwdata[6:0], 6'h0, st.page, st.byteAddr, 33'h0};
              next_st.bitsLeft = next_st.bitsLeft - 7'h1;
            end
            next_st.rdata = '0;
          end
        end
        default: begin
        end
      endcase
    end
    if (st.busy) begin
      if (st.sck && st.rdPend) begin
        // device moves so one cycle after seeing the fall, so take it in the high phase
        next_st.rdata = {st.rdata[30:0], link.soWire};
        next_st.rdPend = 1'b0;
      end
      if (!st.sck) begin
        // rising edge: device samples si
        next_st.sck = 1'b1;
      end else if (st.bitsLeft == 7'h0 && st.rdLeft == 7'h0) begin
        next_st.csN = 1'b1;
        next_st.busy = 1'b0;
        next_st.sck = st.idleHigh;
      end else begin
        next_st.sck = 1'b0;
        if (st.bitsLeft != 7'h0) begin
          next_st.si = st.shOut[63];
          next_st.shOut = {st.shOut[62:0], 1'b0};
          next_st.bitsLeft = st.bitsLeft - 7'h1;
        end else begin
          next_st.rdLeft = st.rdLeft - 7'h1;
          next_st.rdPend = 1'b1;
        end
      end
      if (hdrBits == 7'h0) begin
        next_st.busy = 1'b0;
      end
    end
    if (srst) begin
      next_st = '0;
      next_st.csN = 1'b1;
      next_st.sck = 1'b1;
      next_st.idleHigh = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  assign prdata = st.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign link.csN = st.csN;
  assign link.sck = st.sck;
  assign link.si = st.si;
endmodule : sfcap_host

//--- verif/sfcap_monitor.sv
// checker: link timing seen between host and device ends
`timescale 1ns/100ps
module sfcap_monitor #(
  parameter int SELECT_DELAY = 20
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic soOe,
  input wire logic soWire
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ======================================
  // helpers
  int unsigned upCnt;
  int unsigned riseCnt;
  logic lastSck;
  always_ff @(posedge core_clk) begin
    lastSck <= sck;
    if (srst) begin
      upCnt <= 0;
    end else if (upCnt < SELECT_DELAY) begin
      upCnt <= upCnt + 1;
    end
    if (csN) begin
      riseCnt <= 0;
    end else if (sck && !lastSck) begin
      riseCnt <= riseCnt + 1;
    end
  end
  sequence released;
    $fell(srst);
  endsequence
  sequence bitHigh;
    $rose(sck) && !csN;
  endsequence
  // ======================================
  // assertions
  reset_release_a: assert property (released |-> !soOe && csN)
    else $error("link not idle after reset");
  pullup_idle_a: assert property (!soOe |-> soWire)
    else $error("released output not high");
  select_delay_a: assert property (!csN |-> upCnt >= SELECT_DELAY)
    else $error("select too early after reset");
  drive_select_a: assert property ($rose(soOe) |-> !csN)
    else $error("output driven while deselected");
  release_out_a: assert property ($rose(csN) |-> ##[0:3] !soOe)
    else $error("output not released after deselect");
  data_stable_a: assert property (!csN && sck && $past(sck) |-> $stable(si))
    else $error("input data moved while clock high");
  clock_pulse_a: assert property (bitHigh |=> !sck || csN)
    else $error("clock high phase too long");
  whole_bytes_a: assert property ($rose(csN) |-> riseCnt >= 8 && riseCnt[2:0] == 3'h0)
    else $error("frame not whole bytes");
endmodule : sfcap_monitor

//--- verif/tb_top.sv
// bench top: both ends joined, host driven over APB
`timescale 1ns/100ps
module tb_top;
  localparam int SEL_D = 20;
  localparam int WR_D = 40;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic powerGood = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, mode3, standby, deepDown, cmdValid, pageToBuf, writeReady;
  logic [7:0] cmdOpcode;
  logic [8:0] cmdPage, cmdByte;
  logic [4:0] cmdBlock;
  logic [31:0] lfsr = 32'h16273;
  logic prevSck = 1'b1;
  int error_cnt = 0;
  int compares = 0;
  int validCnt = 0;
  int xferCnt = 0;
  int bits = 0;
  logic [7:0] ops [17] = '{8'h03, 8'h0B, 8'h50, 8'h53, 8'h58, 8'h60, 8'h77, 8'h7C, 8'h81,
                           8'h82, 8'h83, 8'h84, 8'h88, 8'hD1, 8'hD2, 8'hD4, 8'hE8};
  always #5 core_clk = ~core_clk;
  sfcap_link_if link();
  sfcap_host #(.SELECT_DELAY(SEL_D), .WRITE_DELAY(WR_D)) sfcap_host_inst (.core_clk(core_clk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  sfcap_device #(.WRITE_DELAY(WR_D)) sfcap_device_inst (.core_clk(core_clk), .srst(srst),
    .powerGood(powerGood), .link(link), .mode3(mode3), .standby(standby),
    .deepDown(deepDown), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdPage(cmdPage),
    .cmdByte(cmdByte), .cmdBlock(cmdBlock), .pageToBuf(pageToBuf), .writeReady(writeReady));
  sfcap_monitor #(.SELECT_DELAY(SEL_D)) sfcap_monitor_inst (.core_clk(core_clk),
    .srst(srst), .csN(link.csN), .sck(link.sck), .si(link.si), .soOe(link.soOe),
    .soWire(link.soWire));
  always @(posedge core_clk) begin
    if (cmdValid === 1'b1) validCnt++;
    if (pageToBuf === 1'b1) xferCnt++;
    if (link.csN === 1'b0 && link.sck === 1'b1 && prevSck === 1'b0) bits++;
    prevSck = link.sck;
  end
  // ======================================
  // helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic int frameBits(input logic [7:0] op, input logic [2:0] nr);
    int n;
    n = (op inside {8'h9F, 8'hB9, 8'hAB, 8'hD7}) ? 1 : 4;
    n += (op inside {8'h0B, 8'hD4}) ? 1 : (op inside {8'hD2, 8'hE8}) ? 4 : 0;
    return 8 * (n + nr);
  endfunction : frameBits
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) error_cnt++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic frame(input logic [7:0] op, input logic [8:0] pg, input logic [8:0] by,
                       input logic idle, input logic [2:0] nr, output logic [31:0] r);
    int n;
    bits = 0;
    apb(1'b1, 8'h04, {14'h0, pg, by}, r);
    apb(1'b1, 8'h08, {28'h0, idle, nr}, r);
    apb(1'b1, 8'h00, {24'h0, op}, r);
    n = 0;
    do begin
      apb(1'b0, 8'h0C, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 200);
    if (r[0] !== 1'b0) error_cnt++;
    apb(1'b0, 8'h10, 32'h0, r);
    check(32'(bits), 32'(frameBits(op, nr)));
  endtask : frame
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end
  // ======================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic [8:0] pg, by;
    logic idle;
    int v;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    apb(1'b1, 8'h00, 32'h9F, r);
    repeat (3) @(posedge core_clk);
    check(32'(link.csN), 32'h1);
    repeat (SEL_D) @(posedge core_clk);
    apb(1'b1, 8'h00, 32'h81, r);
    repeat (3) @(posedge core_clk);
    check(32'(link.csN), 32'h1);
    // supply still low: the device must stay deaf
    frame(8'h9F, 9'h0, 9'h0, 1'b1, 3'h4, r);
    check(32'(validCnt), 32'h0);
    check(32'(standby), 32'h0);
    powerGood <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(32'(standby), 32'h1);
    check(32'(mode3), 32'h1);
    check(32'(writeReady), 32'h0);
    repeat (WR_D + 2) @(posedge core_clk);
    check(32'(writeReady), 32'h1);
    // every addressed opcode, twice, with random fields and bus mode
    for (int i = 0; i < 34; i++) begin
      pg = rnd();
      by = rnd();
      idle = rnd();
      v = validCnt;
      frame(ops[i % 17], pg, by, idle, 3'h0, r);
      check(32'(validCnt - v), 32'h1);
      check(32'(cmdOpcode), 32'(ops[i % 17]));
      if (ops[i % 17] inside {8'h03, 8'h0B, 8'h53, 8'h58, 8'h60, 8'h81, 8'h82, 8'h83, 8'h88,
                              8'hD2, 8'hE8}) check(32'(cmdPage), 32'(pg));
      if (ops[i % 17] inside {8'h03, 8'h0B, 8'h82, 8'h84, 8'hD1, 8'hD2, 8'hD4, 8'hE8})
        check(32'(cmdByte), 32'(by));
      if (ops[i % 17] == 8'h50) check(32'(cmdBlock), 32'(pg[8:4]));
      check(32'(mode3), 32'(idle));
    end
    check(32'(xferCnt), 32'h2);
    frame(8'h9F, 9'h0, 9'h0, 1'b0, 3'h4, r);
    check(r, {sfcap_pkg::ID_BYTE0, sfcap_pkg::ID_BYTE1, sfcap_pkg::ID_BYTE2,
              sfcap_pkg::ID_BYTE3});
    frame(8'hD7, 9'h0, 9'h0, 1'b1, 3'h1, r);
    check(32'(r[7:0]), 32'h80);
    frame(8'hB9, 9'h0, 9'h0, 1'b1, 3'h0, r);
    check(32'(deepDown), 32'h1);
    frame(8'hAB, 9'h0, 9'h0, 1'b0, 3'h0, r);
    check(32'(deepDown), 32'h0);
    apb(1'b0, 8'h40, 32'h0, r);
    check(r, 32'h0);
    // reset in mid-frame after a mode 0 transfer
    frame(8'h03, 9'h1FF, 9'h0, 1'b0, 3'h0, r);
    apb(1'b1, 8'h00, 32'h03, r);
    repeat (6) @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    check(32'(mode3), 32'h1);
    check(32'(link.soOe), 32'h0);
    repeat (SEL_D + 2) @(posedge core_clk);
    v = validCnt;
    frame(8'h9F, 9'h0, 9'h0, 1'b1, 3'h4, r);
    check(32'(validCnt - v), 32'h1);
    tally_and_finish();
  end
endmodule : tb_top
